/* bench/dtsm_checker.sv */
// port-level assertions for the dual timer block
`timescale 1ns/1ps
module dtsm_checker (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic bit_wr_i,
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_wdata_i,
  input wire logic ack_ext_a_i,
  input wire logic ext_irq_a_input_i,
  input wire logic ext_irq_a_polarity_i,
  input wire logic timer_a_irq_o,
  input wire logic timer_b_irq_o,
  input wire logic ext_irq_a_o,
  input wire logic ext_irq_b_o,
  input wire logic timer_b_ovf_tick_o
);
  logic [7:0] mod_q;
  logic it_q;
  wire act = ext_irq_a_input_i == ext_irq_a_polarity_i;
  wire quiet = !sfr_wr_i && !bit_wr_i;
  wire bsplit = mod_q[1:0] == 2'h3;

  // shadow of mode byte and type bit a, only bus writes touch them
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mod_q <= 8'h00;
      it_q <= 1'h0;
    end else if (clk_en_i) begin
      if (sfr_wr_i && sfr_addr_i == 8'h89) mod_q <= sfr_wdata_i;
      if (sfr_wr_i && sfr_addr_i == 8'h88) it_q <= sfr_wdata_i[0];
      else if (bit_wr_i && bit_addr_i == 8'h88) it_q <= bit_wdata_i;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // reset must be watched while it is asserted, so no disable here
  chk_reset_clear: assert property (disable iff (1'h0)
    srst_i |=> {sfr_rdata_o, timer_a_irq_o, timer_b_irq_o, ext_irq_a_o,
    ext_irq_b_o, timer_b_ovf_tick_o} == 13'h0000)
    else $error("outputs not clear after reset");
  chk_ctl_mirror: assert property (
    sfr_rd_i && sfr_addr_i == 8'h88 |=> {sfr_rdata_o[7], sfr_rdata_o[5],
    sfr_rdata_o[3], sfr_rdata_o[1]} == $past({timer_b_irq_o,
    timer_a_irq_o, ext_irq_b_o, ext_irq_a_o}))
    else $error("flag outputs differ from control byte");
  chk_mode_read: assert property (
    sfr_rd_i && sfr_addr_i == 8'h89 |=> sfr_rdata_o == $past(mod_q))
    else $error("mode byte read back wrong");
  chk_level_set: assert property (
    (!it_q && act) [*4] |=> ext_irq_a_o)
    else $error("level flag not set");
  chk_edge_set: assert property (
    (it_q && !act) [*4] ##1 (it_q && act && quiet && !ack_ext_a_i) [*4]
    |=> ext_irq_a_o)
    else $error("edge flag not set");
  chk_edge_ack: assert property (
    (it_q && !act) [*4] ##0 (ack_ext_a_i && quiet) |=> !ext_irq_a_o)
    else $error("edge flag survived vectoring");
  chk_tick_follow: assert property (
    $rose(timer_b_irq_o) && !bsplit && !$past(sfr_wr_i) && !$past(bit_wr_i)
    |-> timer_b_ovf_tick_o)
    else $error("no overflow tick after flag");
  chk_bit_set: assert property (
    bit_wr_i && bit_addr_i == 8'h8d && bit_wdata_i && !sfr_wr_i
    |=> timer_a_irq_o)
    else $error("single bit write did not set flag");
endmodule

bind dtsm_top dtsm_checker u_chk (.*);

/* bench/dtsm_pins_model.sv */
// far side: count pins and a free-running external clock
`timescale 1ns/1ps
module dtsm_pins_model (
  input wire logic ref_clk_i,
  output logic count_pin_a_o,
  output logic count_pin_b_o,
  output logic ext_clk_o
);
  int ph;

  // pins idle high, clock starts low
  initial begin
    count_pin_a_o = 1'h1;
    count_pin_b_o = 1'h1;
    ext_clk_o = 1'h0;
    ph = 0;
  end

  // six system cycles per period, exactly periodic for window counts
  always @(negedge ref_clk_i) begin
    ph = (ph + 1) % 3;
    if (ph == 0) ext_clk_o = !ext_clk_o;
  end

  // both pins fall together; long phases outlast the resampler
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge ref_clk_i);
      {count_pin_a_o, count_pin_b_o} = 2'h0;
      repeat (4) @(negedge ref_clk_i);
      {count_pin_a_o, count_pin_b_o} = 2'h3;
      repeat (3) @(negedge ref_clk_i);
    end
  endtask
endmodule

/* bench/dtsm_top_test.sv */
// self-checking bench for the dual timer block
`timescale 1ns/1ps
module dtsm_top_test;
  logic clk, rst, wr, rd, bwr, bval, ce;
  logic [7:0] addr, wd, rdat;
  logic [3:0] ack;
  logic [1:0] ii, pl;
  logic [15:0] v;
  logic [16:0] e;
  wire cpa, cpb, xclk, tick;
  int error_cnt, n_tests, ticks, k, r;
  int dv[4] = '{12, 4, 48, 48};

  // clock enable dropped once to prove the timer A count freezes
  dtsm_top dut (
    .ref_clk_i(clk), .srst_i(rst), .clk_en_i(ce),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wd),
    .sfr_rd_i(rd), .sfr_rdata_o(rdat), .bit_wr_i(bwr),
    .bit_addr_i(addr), .bit_wdata_i(bval),
    .ack_timer_a_i(ack[0]), .ack_timer_b_i(ack[1]),
    .ack_ext_a_i(ack[2]), .ack_ext_b_i(ack[3]),
    .count_pin_a_i(cpa), .count_pin_b_i(cpb),
    .ext_irq_a_input_i(ii[0]), .ext_irq_b_input_i(ii[1]),
    .ext_irq_a_polarity_i(pl[0]), .ext_irq_b_polarity_i(pl[1]),
    .ext_clk_i(xclk), .timer_a_irq_o(), .timer_b_irq_o(),
    .ext_irq_a_o(), .ext_irq_b_o(), .timer_b_ovf_tick_o(tick)
  );
  dtsm_pins_model pins (
    .ref_clk_i(clk), .count_pin_a_o(cpa), .count_pin_b_o(cpb),
    .ext_clk_o(xclk)
  );

  always #20 clk = !clk;
  // count tick pulses, one per high cycle
  always @(posedge clk) if (tick === 1'h1) ticks++;

  task automatic chk(input logic [16:0] s, x);
    n_tests++;
    if (s !== x) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, x);
    end
  endtask
  // k: 0 byte write, 1 bit write, 2 read; one idle cycle follows
  task automatic acc(input int k, input logic [7:0] a, d);
    @(negedge clk);
    addr = a;
    wd = d;
    bval = d[0];
    {wr, bwr, rd} = {k == 0, k == 1, k == 2};
    @(negedge clk);
    {wr, bwr, rd} = 3'h0;
  endtask
  task automatic rchk(input logic [7:0] a, x);
    acc(2, a, 8'h00);
    chk({9'h000, rdat}, {9'h000, x});
  endtask
  task automatic ackp(input logic [3:0] m);
    @(negedge clk);
    ack = m;
    @(negedge clk);
    ack = 4'h0;
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // counter after n counts: {overflow seen, high, low}
  function automatic logic [16:0] cnt(input int m, n, input logic [15:0] c);
    logic f;
    f = 1'h0;
    repeat (n) begin
      if (m == 2) begin
        c[7:0] = c[7:0] + 8'h01;
        if (c[7:0] == 8'h00) begin
          c[7:0] = c[15:8];
          f = 1'h1;
        end
      end else if (m == 1) begin
        c = c + 16'h0001;
        f |= c == 16'h0000;
      end else begin
        {c[15:8], c[4:0]} = {c[15:8], c[4:0]} + 13'h0001;
        f |= {c[15:8], c[4:0]} == 13'h0000;
      end
    end
    return {f, c};
  endfunction

  // watchdog at 25000 cycles, far beyond the roughly 1400 cycles needed
  initial begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {clk, wr, rd, bwr, bval, ack, addr, wd} = 0;
    ce = 1'h1;
    rst = 1'h1;
    r = $urandom(32'h87a00a19);
    pl = 2'($urandom);
    ii = ~pl;
    repeat (20) @(negedge clk);
    rst = 1'h0;
    for (int a = 8'h87; a < 8'h90; a++) rchk(8'(a), 8'h00);
    acc(1, 8'h8d, 8'h01);
    acc(1, 8'h8f, 8'h01);
    rchk(8'h88, 8'ha0);
    ackp(4'h1);
    acc(1, 8'h8f, 8'h00);
    rchk(8'h88, 8'h00);
    // every non-split mode on both timers, random preload near wrap
    for (int t = 0; t < 2; t++)
      for (int m = 0; m < 3; m++) begin
        v = {m == 2 ? 8'($urandom) : 8'hff, 8'hf0 | 8'($urandom)};
        k = $urandom_range(40);
        acc(0, 8'h8e, 8'h0c);
        acc(0, 8'h89, 8'(m << (4 * t)));
        rchk(8'h89, 8'(m << (4 * t)));
        acc(0, 8'(8'h8a + t), v[7:0]);
        acc(0, 8'(8'h8c + t), v[15:8]);
        acc(0, 8'h88, 8'h00);
        acc(1, 8'(8'h8c + 2 * t), 8'h01);
        repeat (k) @(negedge clk);
        acc(1, 8'(8'h8c + 2 * t), 8'h00);
        e = cnt(m, k + 2, v);
        rchk(8'(8'h8a + t), e[7:0]);
        rchk(8'(8'h8c + t), e[15:8]);
        rchk(8'h88, 8'({7'h00, e[16]} << (5 + 2 * t)));
      end
    // split: low 6 counts, high 8 counts and wraps, timer b parked
    ticks = 0;
    acc(0, 8'h89, 8'h33);
    acc(0, 8'h8a, 8'hf8);
    acc(0, 8'h8c, 8'hfc);
    acc(0, 8'h8b, 8'hff);
    acc(0, 8'h8d, 8'hff);
    acc(0, 8'h88, 8'h50);
    repeat (4) @(negedge clk);
    acc(1, 8'h8c, 8'h00);
    acc(1, 8'h8e, 8'h00);
    rchk(8'h8a, 8'hfe);
    rchk(8'h8c, 8'h04);
    rchk(8'h88, 8'h80);
    rchk(8'h8b, 8'hff);
    ackp(4'h2);
    acc(0, 8'h89, 8'h13);
    repeat (2) @(negedge clk);
    acc(0, 8'h89, 8'h33);
    rchk(8'h8b, 8'h03);
    rchk(8'h88, 8'h00);
    chk(17'(ticks), 17'h00001);
    // count pins: a gated by its irq input, b free
    for (int a = 8'h8a; a < 8'h8e; a++) acc(0, 8'(a), 8'h00);
    acc(0, 8'h89, 8'h4d);
    acc(0, 8'h88, 8'h50);
    pins.pulse(3);
    ii[0] = pl[0];
    repeat (4) @(negedge clk);
    pins.pulse(5);
    ii[0] = !pl[0];
    repeat (4) @(negedge clk);
    acc(0, 8'h88, 8'h00);
    rchk(8'h8a, 8'h05);
    rchk(8'h8b, 8'h08);
    // frozen cycles must not count: only the two enabled edges do
    acc(0, 8'h89, 8'h01);
    acc(0, 8'h8e, 8'h0c);
    acc(0, 8'h8a, 8'h00);
    acc(1, 8'h8c, 8'h01);
    ce = 1'h0;
    repeat (10) @(negedge clk);
    ce = 1'h1;
    acc(1, 8'h8c, 8'h00);
    rchk(8'h8a, 8'h02);
    // prescaler: 96-count window after settling
    foreach (dv[p]) begin
      acc(0, 8'h8e, 8'(p));
      acc(0, 8'h8a, 8'h00);
      acc(0, 8'h8c, 8'h00);
      repeat (100) @(negedge clk);
      acc(1, 8'h8c, 8'h01);
      repeat (94) @(negedge clk);
      acc(1, 8'h8c, 8'h00);
      rchk(8'h8a, 8'(96 / dv[p]));
    end
    // external flags, both inputs, level then edge
    for (int x = 0; x < 2; x++)
      for (int y = 0; y < 2; y++) begin
        acc(0, 8'h88, 8'(y * 5));
        ii[x] = pl[x];
        repeat (6) @(negedge clk);
        rchk(8'h88, 8'(y * 5 + (2 << 2 * x)));
        ackp(4'(4 << x));
        rchk(8'h88, 8'(y * 5 + (y ? 0 : 2 << 2 * x)));
        ii[x] = !pl[x];
        repeat (4) @(negedge clk);
        ackp(4'(4 << x));
        acc(0, 8'h88, 8'(y * 5));
        rchk(8'h88, 8'(y * 5));
      end
    tally_and_finish();
  end
endmodule

/* hdl/dtsm_prescaler.sv */
// shared prescaled tick: system clock /12, /4, /48 or external clock /8
`timescale 1ns/1ps
`include "dtsm_cfg.svh"
module dtsm_prescaler (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic ext_clk_i,
  dtsm_psc_if.psc bus
);
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_prev_q;
  logic [5:0] cnt_q;
  logic [5:0] last;
  logic step;
  logic tick_q;

  // external clock resampled before its falling edge is counted
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      ext_s1_q <= ext_clk_i;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
    end
  end

  // terminal count and advance condition per selection
  always_comb begin
    step = 1'b1;
    unique case (bus.sel)
      dtsm_pkg::DTSM_PSC_SYS12: last = `DTSM_PSC_DIV12_LAST;
      dtsm_pkg::DTSM_PSC_SYS4: last = `DTSM_PSC_DIV4_LAST;
      dtsm_pkg::DTSM_PSC_SYS48: last = `DTSM_PSC_DIV48_LAST;
      dtsm_pkg::DTSM_PSC_EXT8: begin
        last = `DTSM_PSC_EXT8_LAST;
        step = ext_prev_q & ~ext_s2_q;
      end
    endcase
  end

  // >= so a change of selection never strands the counter above its end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (clk_en_i) begin
      tick_q <= 1'b0;
      if (step) begin
        if (cnt_q >= last) begin
          cnt_q <= 6'h00;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end

  assign bus.tick = tick_q;
endmodule

/* hdl/dtsm_top.sv */
// dual timer with split mode, control/status and mode registers
`timescale 1ns/1ps
`include "dtsm_cfg.svh"
// Summary of operation
// - split mode turns timer A into two independent 8-bit counters
// - split low byte uses timer A run, source, gate and overflow bits
// - split low byte counts internal clock or count pin per source select
// - split high byte counts internal ticks only, run by timer B run bit
// - split high byte overflow sets timer B overflow flag
// - during split, timer B counts internally, never sets its flag
// - timer B overflow pulses still leave as baud and conversion tick
// - during split, timer B runs in modes 0-2 and stops in mode 3
// - overflow flags set by hardware, cleared by zero write or vectoring
// - run bit at one enables a timer, subject to its gate
// - external flags set per type, cleared by write or edge-mode vectoring
// - type select zero means level, one means edge; polarity is separate
// - gate one also needs the external input at its active level
// - source select one counts falling edges on the count pin
// - timer B mode field: 13-bit, 16-bit, reload 8-bit, inactive
// - timer A mode field: 13-bit, 16-bit, reload 8-bit, split
// - control/status register is bit addressable and resets to zero
// - 13-bit mode wraps at 0x1fff, 16-bit mode uses all bits
// - reload mode counts low byte and reloads from unchanged high byte
// - prescaled tick is sysclk /12, /4, /48 or external clock /8
// - clock select one uses raw system clock, zero the prescaled tick
module dtsm_top (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic bit_wr_i,
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_wdata_i,
  input wire logic ack_timer_a_i,
  input wire logic ack_timer_b_i,
  input wire logic ack_ext_a_i,
  input wire logic ack_ext_b_i,
  input wire logic count_pin_a_i,
  input wire logic count_pin_b_i,
  input wire logic ext_irq_a_input_i,
  input wire logic ext_irq_b_input_i,
  input wire logic ext_irq_a_polarity_i,
  input wire logic ext_irq_b_polarity_i,
  input wire logic ext_clk_i,
  output logic timer_a_irq_o,
  output logic timer_b_irq_o,
  output logic ext_irq_a_o,
  output logic ext_irq_b_o,
  output logic timer_b_ovf_tick_o
);
  logic [7:0] timer_control_status_q;
  logic [7:0] timer_control_status_d;
  logic [7:0] timer_mode_select_q;
  logic [7:0] timer_clock_config_register_q;
  logic [7:0] tl0_q;
  logic [7:0] th0_q;
  logic [7:0] tl1_q;
  logic [7:0] th1_q;
  logic [7:0] rdata_q;
  logic tick_q;
  logic [3:0] raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] prev_q;
  logic [3:0] fall;
  logic [7:0] sw_en;
  logic [7:0] sw_val;
  logic [7:0] hw_set;
  logic [7:0] hw_clr;
  dtsm_pkg::dtsm_mode_t mode_a;
  dtsm_pkg::dtsm_mode_t mode_b;
  logic split;
  logic act_a;
  logic act_b;
  logic act_a_prev;
  logic act_b_prev;
  logic tclk_a;
  logic tclk_b;
  logic ta_inc;
  logic th_split_inc;
  logic tb_inc;
  logic [16:0] step_a;
  logic [16:0] step_b;
  logic ta_ovf;
  logic th_split_ovf;
  logic tb_ovf;

  dtsm_psc_if psc_bus ();

  dtsm_prescaler u_psc (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .clk_en_i(clk_en_i),
    .ext_clk_i(ext_clk_i),
    .bus(psc_bus)
  );

  assign psc_bus.sel = dtsm_pkg::dtsm_psc_t'(timer_clock_config_register_q[1:0]);

  // byte write strobe for one register address
  function automatic logic dtsm_byte_wr(input logic wr,
                                        input logic [7:0] addr,
                                        input logic [7:0] target);
    dtsm_byte_wr = wr && (addr == target);
  endfunction

  // one count step of a non-split timer: {overflow, high, low}
  function automatic logic [16:0] dtsm_step(
      input dtsm_pkg::dtsm_mode_t mode,
      input logic [7:0] tl,
      input logic [7:0] th);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [7:0] l8;
    c13 = {th, tl[4:0]} + 13'h0001;
    c16 = {th, tl} + 16'h0001;
    l8 = tl + 8'h01;
    unique case (mode)
      dtsm_pkg::DTSM_MODE_13BIT: begin
        // upper three low-byte bits are left untouched
        dtsm_step = {c13 == 13'h0000, c13[12:5], tl[7:5], c13[4:0]};
      end
      dtsm_pkg::DTSM_MODE_16BIT: begin
        dtsm_step = {c16 == 16'h0000, c16};
      end
      dtsm_pkg::DTSM_MODE_RELOAD8: begin
        if (tl == 8'hff) begin
          dtsm_step = {1'b1, th, th};
        end else begin
          dtsm_step = {1'b0, th, l8};
        end
      end
      dtsm_pkg::DTSM_MODE_SPLIT: begin
        // callers never step a split or inactive timer through here
        dtsm_step = {1'b0, th, tl};
      end
    endcase
  endfunction

  // pin and gate resampling; edges seen only past the second stage
  assign raw = {ext_irq_b_input_i, ext_irq_a_input_i,
                count_pin_b_i, count_pin_a_i};
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
        prev_q[i] <= 1'b0;
      end else if (clk_en_i) begin
        sync1_q[i] <= raw[i];
        sync2_q[i] <= sync1_q[i];
        prev_q[i] <= sync2_q[i];
      end
    end
    assign fall[i] = prev_q[i] & ~sync2_q[i];
  end

  // external input active levels follow the outside polarity settings
  assign act_a = sync2_q[2] == ext_irq_a_polarity_i;
  assign act_b = sync2_q[3] == ext_irq_b_polarity_i;
  assign act_a_prev = prev_q[2] == ext_irq_a_polarity_i;
  assign act_b_prev = prev_q[3] == ext_irq_b_polarity_i;

  // mode decode for both timers
  assign mode_a = dtsm_pkg::dtsm_mode_t'(timer_mode_select_q[`DTSM_TIMER_MODE_SELECT_T0M_HI:
                                               `DTSM_TIMER_MODE_SELECT_T0M_LO]);
  assign mode_b = dtsm_pkg::dtsm_mode_t'(timer_mode_select_q[`DTSM_TIMER_MODE_SELECT_T1M_HI:
                                               `DTSM_TIMER_MODE_SELECT_T1M_LO]);
  assign split = mode_a == dtsm_pkg::DTSM_MODE_SPLIT;

  // internal timebase per timer
  assign tclk_a = timer_clock_config_register_q[`DTSM_TIMER_CLOCK_CONFIG_REGISTER_T0CLK] | psc_bus.tick;
  assign tclk_b = timer_clock_config_register_q[`DTSM_TIMER_CLOCK_CONFIG_REGISTER_T1CLK] | psc_bus.tick;

  // timer A increment: run, gate, then source
  always_comb begin
    ta_inc = timer_control_status_q[`DTSM_TIMER_CONTROL_STATUS_TR0]
           & (~timer_mode_select_q[`DTSM_TIMER_MODE_SELECT_TIMER_A_GATE_BIT] | act_a)
           & (timer_mode_select_q[`DTSM_TIMER_MODE_SELECT_CT0] ? fall[0] : tclk_a);
    th_split_inc = split & timer_control_status_q[`DTSM_TIMER_CONTROL_STATUS_TR1] & tclk_a;
  end

  // timer B increment; in split it is run by its mode, internal only
  always_comb begin
    if (split) begin
      tb_inc = (mode_b != dtsm_pkg::DTSM_MODE_SPLIT) & tclk_b;
    end else begin
      tb_inc = (mode_b != dtsm_pkg::DTSM_MODE_SPLIT)
             & timer_control_status_q[`DTSM_TIMER_CONTROL_STATUS_TR1]
             & (~timer_mode_select_q[`DTSM_TIMER_MODE_SELECT_TIMER_B_GATE_BIT] | act_b)
             & (timer_mode_select_q[`DTSM_TIMER_MODE_SELECT_CT1] ? fall[1] : tclk_b);
    end
  end

  assign step_a = dtsm_step(mode_a, tl0_q, th0_q);
  assign step_b = dtsm_step(mode_b, tl1_q, th1_q);

  // overflow events of all three counters
  always_comb begin
    if (split) begin
      ta_ovf = ta_inc & (tl0_q == 8'hff);
    end else begin
      ta_ovf = ta_inc & step_a[16];
    end
    th_split_ovf = th_split_inc & (th0_q == 8'hff);
    tb_ovf = tb_inc & step_b[16];
  end

  // timer A counter bytes; a software write outranks a count
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tl0_q <= `DTSM_REG_RESET;
      th0_q <= `DTSM_REG_RESET;
    end else if (clk_en_i) begin
      if (split) begin
        if (ta_inc) begin
          tl0_q <= tl0_q + 8'h01;
        end
        if (th_split_inc) begin
          th0_q <= th0_q + 8'h01;
        end
      end else if (ta_inc) begin
        tl0_q <= step_a[7:0];
        th0_q <= step_a[15:8];
      end
      if (dtsm_byte_wr(sfr_wr_i, sfr_addr_i, `DTSM_TL0_ADDR)) begin
        tl0_q <= sfr_wdata_i;
      end
      if (dtsm_byte_wr(sfr_wr_i, sfr_addr_i, `DTSM_TH0_ADDR)) begin
        th0_q <= sfr_wdata_i;
      end
    end
  end

  // timer B counter bytes
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tl1_q <= `DTSM_REG_RESET;
      th1_q <= `DTSM_REG_RESET;
    end else if (clk_en_i) begin
      if (tb_inc) begin
        tl1_q <= step_b[7:0];
        th1_q <= step_b[15:8];
      end
      if (dtsm_byte_wr(sfr_wr_i, sfr_addr_i, `DTSM_TL1_ADDR)) begin
        tl1_q <= sfr_wdata_i;
      end
      if (dtsm_byte_wr(sfr_wr_i, sfr_addr_i, `DTSM_TH1_ADDR)) begin
        th1_q <= sfr_wdata_i;
      end
    end
  end

  // software access to control/status: whole byte or single bit
  always_comb begin
    sw_en = 8'h00;
    sw_val = 8'h00;
    if (dtsm_byte_wr(sfr_wr_i, sfr_addr_i, `DTSM_TIMER_CONTROL_STATUS_ADDR)) begin
      sw_en = 8'hff;
      sw_val = sfr_wdata_i;
    end else if (bit_wr_i && bit_addr_i[7:3] == `DTSM_TIMER_CONTROL_STATUS_BITBASE) begin
      sw_en[bit_addr_i[2:0]] = 1'b1;
      sw_val = {8{bit_wdata_i}};
    end
  end

  // hardware sets and vectoring clears of the four flags
  always_comb begin
    hw_set = 8'h00;
    hw_clr = 8'h00;
    hw_set[`DTSM_TIMER_CONTROL_STATUS_TF0] = ta_ovf;
    hw_set[`DTSM_TIMER_CONTROL_STATUS_TF1] = split ? th_split_ovf : tb_ovf;
    hw_set[`DTSM_TIMER_CONTROL_STATUS_IE0] = timer_control_status_q[`DTSM_TIMER_CONTROL_STATUS_IT0]
                           ? act_a & ~act_a_prev : act_a;
    hw_set[`DTSM_TIMER_CONTROL_STATUS_IE1] = timer_control_status_q[`DTSM_TIMER_CONTROL_STATUS_IT1]
                           ? act_b & ~act_b_prev : act_b;
    hw_clr[`DTSM_TIMER_CONTROL_STATUS_TF0] = ack_timer_a_i;
    hw_clr[`DTSM_TIMER_CONTROL_STATUS_TF1] = ack_timer_b_i;
    // level-mode flags stay put on vectoring; only a software write clears them
    hw_clr[`DTSM_TIMER_CONTROL_STATUS_IE0] = ack_ext_a_i & timer_control_status_q[`DTSM_TIMER_CONTROL_STATUS_IT0];
    hw_clr[`DTSM_TIMER_CONTROL_STATUS_IE1] = ack_ext_b_i & timer_control_status_q[`DTSM_TIMER_CONTROL_STATUS_IT1];
  end

  // per bit: hardware set first, then software value, then vector clear
  for (genvar b = 0; b < 8; b++) begin : g_timer_control_status
    always_comb begin
      if (hw_set[b]) begin
        timer_control_status_d[b] = 1'b1;
      end else if (sw_en[b]) begin
        timer_control_status_d[b] = sw_val[b];
      end else if (hw_clr[b]) begin
        timer_control_status_d[b] = 1'b0;
      end else begin
        timer_control_status_d[b] = timer_control_status_q[b];
      end
    end
  end

  // control/status register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      timer_control_status_q <= `DTSM_REG_RESET;
    end else if (clk_en_i) begin
      timer_control_status_q <= timer_control_status_d;
    end
  end

  // mode and clock-select registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      timer_mode_select_q <= `DTSM_REG_RESET;
      timer_clock_config_register_q <= `DTSM_REG_RESET;
    end else if (clk_en_i) begin
      if (dtsm_byte_wr(sfr_wr_i, sfr_addr_i, `DTSM_TIMER_MODE_SELECT_ADDR)) begin
        timer_mode_select_q <= sfr_wdata_i;
      end
      // only the timer A/B clock and prescale bits live here
      if (dtsm_byte_wr(sfr_wr_i, sfr_addr_i, `DTSM_TIMER_CLOCK_CONFIG_REGISTER_ADDR)) begin
        timer_clock_config_register_q <= sfr_wdata_i & `DTSM_TIMER_CLOCK_CONFIG_REGISTER_MASK;
      end
    end
  end

  // read data held until the next read strobe
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
    end else if (clk_en_i && sfr_rd_i) begin
      case (sfr_addr_i)
        `DTSM_TIMER_CONTROL_STATUS_ADDR: rdata_q <= timer_control_status_q;
        `DTSM_TIMER_MODE_SELECT_ADDR: rdata_q <= timer_mode_select_q;
        `DTSM_TL0_ADDR: rdata_q <= tl0_q;
        `DTSM_TL1_ADDR: rdata_q <= tl1_q;
        `DTSM_TH0_ADDR: rdata_q <= th0_q;
        `DTSM_TH1_ADDR: rdata_q <= th1_q;
        `DTSM_TIMER_CLOCK_CONFIG_REGISTER_ADDR: rdata_q <= timer_clock_config_register_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // timer B overflow pulse for serial baud and converter start
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tick_q <= 1'b0;
    end else if (clk_en_i) begin
      tick_q <= tb_ovf;
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign timer_a_irq_o = timer_control_status_q[`DTSM_TIMER_CONTROL_STATUS_TF0];
  assign timer_b_irq_o = timer_control_status_q[`DTSM_TIMER_CONTROL_STATUS_TF1];
  assign ext_irq_a_o = timer_control_status_q[`DTSM_TIMER_CONTROL_STATUS_IE0];
  assign ext_irq_b_o = timer_control_status_q[`DTSM_TIMER_CONTROL_STATUS_IE1];
  assign timer_b_ovf_tick_o = tick_q;
endmodule

/* include/dtsm_cfg.svh */
// register addresses, field positions and prescale counts for the timer pair
`ifndef DTSM_CFG_SVH
`define DTSM_CFG_SVH
`define DTSM_TIMER_CONTROL_STATUS_ADDR 8'h88
`define DTSM_TIMER_MODE_SELECT_ADDR 8'h89
`define DTSM_TL0_ADDR 8'h8a
`define DTSM_TL1_ADDR 8'h8b
`define DTSM_TH0_ADDR 8'h8c
`define DTSM_TH1_ADDR 8'h8d
`define DTSM_TIMER_CLOCK_CONFIG_REGISTER_ADDR 8'h8e
`define DTSM_TIMER_CONTROL_STATUS_BITBASE 5'h11
`define DTSM_REG_RESET 8'h00
`define DTSM_TIMER_CONTROL_STATUS_TF1 7
`define DTSM_TIMER_CONTROL_STATUS_TR1 6
`define DTSM_TIMER_CONTROL_STATUS_TF0 5
`define DTSM_TIMER_CONTROL_STATUS_TR0 4
`define DTSM_TIMER_CONTROL_STATUS_IE1 3
`define DTSM_TIMER_CONTROL_STATUS_IT1 2
`define DTSM_TIMER_CONTROL_STATUS_IE0 1
`define DTSM_TIMER_CONTROL_STATUS_IT0 0
`define DTSM_TIMER_MODE_SELECT_TIMER_B_GATE_BIT 7
`define DTSM_TIMER_MODE_SELECT_CT1 6
`define DTSM_TIMER_MODE_SELECT_T1M_HI 5
`define DTSM_TIMER_MODE_SELECT_T1M_LO 4
`define DTSM_TIMER_MODE_SELECT_TIMER_A_GATE_BIT 3
`define DTSM_TIMER_MODE_SELECT_CT0 2
`define DTSM_TIMER_MODE_SELECT_T0M_HI 1
`define DTSM_TIMER_MODE_SELECT_T0M_LO 0
`define DTSM_TIMER_CLOCK_CONFIG_REGISTER_T1CLK 3
`define DTSM_TIMER_CLOCK_CONFIG_REGISTER_T0CLK 2
`define DTSM_TIMER_CLOCK_CONFIG_REGISTER_MASK 8'h0f
`define DTSM_PSC_DIV12_LAST 6'h0b
`define DTSM_PSC_DIV4_LAST 6'h03
`define DTSM_PSC_DIV48_LAST 6'h2f
`define DTSM_PSC_EXT8_LAST 6'h07
`endif

/* include/dtsm_pkg.sv */
// types shared by the timer pair and its prescaler
package dtsm_pkg;
  typedef enum logic [1:0] {
    DTSM_MODE_13BIT,
    DTSM_MODE_16BIT,
    DTSM_MODE_RELOAD8,
    DTSM_MODE_SPLIT
  } dtsm_mode_t;
  typedef enum logic [1:0] {
    DTSM_PSC_SYS12,
    DTSM_PSC_SYS4,
    DTSM_PSC_SYS48,
    DTSM_PSC_EXT8
  } dtsm_psc_t;
endpackage

/* include/dtsm_psc_if.sv */
// carrier between the timer core and the shared prescaler
`timescale 1ns/1ps
interface dtsm_psc_if;
  dtsm_pkg::dtsm_psc_t sel;
  logic tick;
  modport core (output sel, input tick);
  modport psc (input sel, output tick);
endinterface
